//--- pkg/opanel_map.vh
// Constants for the operator panel control block
// Notes on behaviour
// - Eighteen address lamps show counter; top unused
// - Address clear zeroes the whole address counter
// - Address switch sets its bit only
// - Running program: address switches ignored, lamps dark
// - Lamp shows time-of-day lines disabled
// - Lamp shows interval timer decrement inhibited
// - Lockout leaves only jumps, stop releases active
// - Lamp shows halt on parity configured
// - Four memory fault lamps, one per pair
// - Instruction fault lamp on illegal operation code
// - Jump select lights/enables; release clears; lockout-proof
// - Manual jump halts on field 4 or lit stop
// - Halt lights release-stop lamp; start clears, resumes
// - Guard or lockout: manual jump never halts
// - Fault clear spares clock fault; alarm silence
// - Channel clear resets I/O and subsystems
// - Processor clear resets; start runs from counter
// - Stop halts instructions, I/O continues
// - Six-digit 24-hour clock wraps to zero
// - Lockout ignores all ten clock switches
// - Clock start, stop, clear, fault reset
// - Six stepping switches advance stopped clock digits
`ifndef OPANEL_MAP_VH
`define OPANEL_MAP_VH

// Register byte offsets
`define OP_ADDR_CTRL 12'h000
`define OP_ADDR_PAC 12'h004
`define OP_ADDR_LAMPS 12'h008
`define OP_ADDR_TOD 12'h00c

// Control register fields
`define OP_CTRL_LOCKOUT 0
`define OP_CTRL_GUARD 1
`define OP_CTRL_PARITY_HALT 2
`define OP_CTRL_TOD_DIS 3
`define OP_CTRL_ITMR_DIS 4
`define OP_CTRL_W 5
`define OP_CTRL_RESET 5'h00

// Panel switch vector layout
`define OP_SW_W 47
`define OP_SW_ADDR 0
`define OP_SW_ACLR 17
`define OP_SW_JSEL 18
`define OP_SW_JREL 21
`define OP_SW_SSEL 24
`define OP_SW_SREL 27
`define OP_SW_FCLR 30
`define OP_SW_ALM 31
`define OP_SW_BOOT 32
`define OP_SW_CHCLR 33
`define OP_SW_PCLR 34
`define OP_SW_START 35
`define OP_SW_STOP 36
`define OP_SW_TOD 37

// Time-of-day switch order within the ten-bit group
`define OP_TOD_FRST 0
`define OP_TOD_START 1
`define OP_TOD_STOP 2
`define OP_TOD_CLEAR 3
`define OP_TOD_STEP 4

// Manual jump field value that stops whatever the stop select lamps show, unless guard or lockout is set
`define OP_JFIELD_ALWAYS 3'h4

// Digit limits: hours tens, hours units, minutes, hundredths
`define OP_LIM_HT 4'h2
`define OP_LIM_HU 4'h9
`define OP_LIM_HU_AT_20 4'h3
`define OP_LIM_MT 4'h5
`define OP_LIM_DEC 4'h9

// One hundredth of a minute, in nanoseconds, and the clock period
`define OP_TICK_NS 600000000
`define OP_CLK_NS 4

`endif

//--- src/opanel_ctrl.v
// Operator panel control: address counter, lamps, jumps, stops, day clock
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
`include "opanel_map.vh"

module opanel_ctrl #(
    parameter TICK_CYCLES = `OP_TICK_NS / `OP_CLK_NS
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Panel switches, asynchronous momentary contacts
    input wire [16:0] i_addr_switches,
    input wire i_address_clear_switch,
    input wire [2:0] i_jump_select_switches,
    input wire [2:0] i_jump_release_switches,
    input wire [2:0] i_stop_select_switches,
    input wire [2:0] i_stop_release_switches,
    input wire i_fault_lamp_clear_switch,
    input wire i_alarm_silence_switch,
    input wire i_bootstrap_load_switch,
    input wire i_channel_clear_switch,
    input wire i_processor_clear_switch,
    input wire i_start_switch,
    input wire i_stop_switch,
    input wire [9:0] i_tod_switches,
    // Processor control section, same clock
    input wire i_cpu_running,
    input wire i_pac_load,
    input wire [16:0] i_pac_value,
    input wire i_mj_valid,
    input wire [2:0] i_mj_jfield,
    input wire [3:0] i_mem_parity_err,
    input wire i_illegal_op,
    input wire i_cond_fault,
    input wire i_console_fault,
    input wire i_tod_transient,
    // Lamps
    output reg [17:0] o_pac_lamps,
    output reg o_tod_disable_lamp,
    output reg o_interval_timer_disable_lamp,
    output reg o_guard_lamp,
    output reg o_lockout_lamp,
    output reg o_parity_halt_lamp,
    output reg [3:0] o_mem_fault_lamps,
    output reg o_instruction_fault_lamp,
    output reg o_processor_condition_lamp,
    output reg o_console_fault_lamp,
    output reg o_tod_fault_lamp,
    output reg o_alarm,
    output reg [2:0] o_jump_select_lamps,
    output reg [2:0] o_stop_select_lamps,
    output reg [3:0] o_stop_release_lamps,
    // Commands to the processor and channels
    output reg [17:0] o_pac,
    output reg [2:0] o_jump_enable,
    output reg o_mj_halt,
    output reg o_cpu_start,
    output reg o_cpu_stop,
    output reg o_cpu_clear,
    output reg o_io_clear,
    output reg o_master_clear,
    output reg o_bootstrap_load,
    output reg [23:0] o_tod
);

////////////////////////////////////////////////////////////////////////////////
// Switch synchronisers and press detection

wire [`OP_SW_W-1:0] sw_raw;
reg [`OP_SW_W-1:0] sw_meta_reg;
reg [`OP_SW_W-1:0] sw_sync_reg;
reg [`OP_SW_W-1:0] sw_last_reg;
wire [`OP_SW_W-1:0] press;

assign sw_raw = {i_tod_switches, i_stop_switch, i_start_switch, i_processor_clear_switch,
                 i_channel_clear_switch, i_bootstrap_load_switch, i_alarm_silence_switch,
                 i_fault_lamp_clear_switch, i_stop_release_switches, i_stop_select_switches,
                 i_jump_release_switches, i_jump_select_switches, i_address_clear_switch,
                 i_addr_switches};

// Holding a switch down gives one action only
always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        sw_meta_reg <= {`OP_SW_W{1'b0}};
        sw_sync_reg <= {`OP_SW_W{1'b0}};
        sw_last_reg <= {`OP_SW_W{1'b0}};
    end else begin
        sw_meta_reg <= sw_raw;
        sw_sync_reg <= sw_meta_reg;
        sw_last_reg <= sw_sync_reg;
    end
end

assign press = sw_sync_reg & ~sw_last_reg;

reg [`OP_CTRL_W-1:0] ctrl_reg;
wire lockout = ctrl_reg[`OP_CTRL_LOCKOUT];
wire guard = ctrl_reg[`OP_CTRL_GUARD];
wire panel_ok = ~lockout;

wire [16:0] p_addr = press[`OP_SW_ADDR +: 17];
wire p_aclr = press[`OP_SW_ACLR];
wire [2:0] p_jsel = press[`OP_SW_JSEL +: 3];
wire [2:0] p_jrel = press[`OP_SW_JREL +: 3];
wire [2:0] p_ssel = press[`OP_SW_SSEL +: 3];
wire [2:0] p_srel = press[`OP_SW_SREL +: 3];
wire p_fclr = press[`OP_SW_FCLR] & panel_ok;
wire p_alm = press[`OP_SW_ALM] & panel_ok;
wire p_start = press[`OP_SW_START] & panel_ok;
wire [9:0] p_tod = press[`OP_SW_TOD +: 10] & {10{~lockout}};

////////////////////////////////////////////////////////////////////////////////
// Program address counter

wire addr_ok = panel_ok & ~i_cpu_running;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_pac <= 18'h00000;
        o_pac_lamps <= 18'h00000;
    end else begin
        if (i_pac_load) begin
            o_pac <= {1'b0, i_pac_value};
        end else if (addr_ok && p_aclr) begin
            o_pac <= 18'h00000;
        end else if (addr_ok) begin
            o_pac <= o_pac | {1'b0, p_addr};
        end
        // Lamps go dark while the program runs; bit 17 never lights
        o_pac_lamps <= i_cpu_running ? 18'h00000 : {1'b0, o_pac[16:0]};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Mode, disable and fault lamps

wire fault_evt = (|i_mem_parity_err) | i_illegal_op | i_cond_fault | i_console_fault
                 | i_tod_transient;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_tod_disable_lamp <= 1'b0;
        o_interval_timer_disable_lamp <= 1'b0;
        o_guard_lamp <= 1'b0;
        o_lockout_lamp <= 1'b0;
        o_parity_halt_lamp <= 1'b0;
        o_mem_fault_lamps <= 4'h0;
        o_instruction_fault_lamp <= 1'b0;
        o_processor_condition_lamp <= 1'b0;
        o_console_fault_lamp <= 1'b0;
        o_tod_fault_lamp <= 1'b0;
        o_alarm <= 1'b0;
    end else begin
        o_tod_disable_lamp <= ctrl_reg[`OP_CTRL_TOD_DIS];
        o_interval_timer_disable_lamp <= ctrl_reg[`OP_CTRL_ITMR_DIS];
        o_guard_lamp <= guard;
        o_lockout_lamp <= lockout;
        o_parity_halt_lamp <= ctrl_reg[`OP_CTRL_PARITY_HALT];
        // A fault arriving with the clear press wins over the clear
        o_mem_fault_lamps <= (o_mem_fault_lamps & {4{~p_fclr}}) | i_mem_parity_err;
        o_instruction_fault_lamp <= (o_instruction_fault_lamp & ~p_fclr) | i_illegal_op;
        o_processor_condition_lamp <= (o_processor_condition_lamp & ~p_fclr) | i_cond_fault;
        o_console_fault_lamp <= (o_console_fault_lamp & ~p_fclr) | i_console_fault;
        // The clock fault lamp has its own reset among the clock switches
        o_tod_fault_lamp <= (o_tod_fault_lamp & ~p_tod[`OP_TOD_FRST]) | i_tod_transient;
        o_alarm <= (o_alarm & ~p_alm) | fault_evt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Jumps, stops and processor commands

wire [1:0] jidx = i_mj_jfield[1:0];
wire stop_hit = (i_mj_jfield == `OP_JFIELD_ALWAYS) |
                (i_mj_jfield[2] & (jidx != 2'b00) & o_stop_select_lamps[jidx - 2'b01]);
wire mj_stop = i_mj_valid & ~guard & ~lockout & stop_hit;

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_jump_select_lamps <= 3'h0;
        o_jump_enable <= 3'h0;
        o_stop_select_lamps <= 3'h0;
        o_stop_release_lamps <= 4'h0;
        o_mj_halt <= 1'b0;
        o_cpu_start <= 1'b0;
        o_cpu_stop <= 1'b0;
        o_cpu_clear <= 1'b0;
        o_io_clear <= 1'b0;
        o_master_clear <= 1'b0;
        o_bootstrap_load <= 1'b0;
    end else begin
        // Release wins when select and release are pressed together
        o_jump_select_lamps <= (o_jump_select_lamps | p_jsel) & ~p_jrel;
        o_jump_enable <= (o_jump_select_lamps | p_jsel) & ~p_jrel;
        o_stop_select_lamps <= (o_stop_select_lamps | (p_ssel & {3{panel_ok}})) & ~p_srel;
        if (mj_stop) begin
            o_stop_release_lamps <= 4'h1 << jidx;
        end else if (p_start) begin
            o_stop_release_lamps <= 4'h0;
        end
        o_mj_halt <= mj_stop;
        o_cpu_start <= p_start;
        o_cpu_stop <= press[`OP_SW_STOP] & panel_ok;
        o_cpu_clear <= press[`OP_SW_PCLR] & panel_ok;
        o_io_clear <= press[`OP_SW_CHCLR] & panel_ok;
        o_master_clear <= press[`OP_SW_CHCLR] & panel_ok;
        o_bootstrap_load <= press[`OP_SW_BOOT] & panel_ok;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Time-of-day counter, BCD hh mm cc

reg tod_run_reg;
reg [31:0] tick_cnt_reg;
wire tick = tod_run_reg & (tick_cnt_reg == TICK_CYCLES - 1);

wire [3:0] d_ht = o_tod[23:20];
wire [3:0] d_hu = o_tod[19:16];
wire [3:0] d_mt = o_tod[15:12];
wire [3:0] d_mu = o_tod[11:8];
wire [3:0] d_ct = o_tod[7:4];
wire [3:0] d_cu = o_tod[3:0];
wire [3:0] hu_lim = (d_ht == `OP_LIM_HT) ? `OP_LIM_HU_AT_20 : `OP_LIM_HU;

// Next value of one digit and whether it wrapped
function [4:0] dstep;
    input [3:0] d;
    input [3:0] lim;
    begin
        dstep = (d >= lim) ? {1'b1, 4'h0} : {1'b0, d + 4'h1};
    end
endfunction

wire [4:0] n_cu = dstep(d_cu, `OP_LIM_DEC);
wire [4:0] n_ct = dstep(d_ct, `OP_LIM_DEC);
wire [4:0] n_mu = dstep(d_mu, `OP_LIM_DEC);
wire [4:0] n_mt = dstep(d_mt, `OP_LIM_MT);
wire [4:0] n_hu = dstep(d_hu, hu_lim);
wire [4:0] n_ht = dstep(d_ht, `OP_LIM_HT);

reg [23:0] tod_next;
always @* begin
    tod_next = o_tod;
    // Carry ripple from hundredths up; 23:59.99 rolls to 00:00.00
    if (tick) begin
        tod_next[3:0] = n_cu[3:0];
        if (n_cu[4]) begin
            tod_next[7:4] = n_ct[3:0];
            if (n_ct[4]) begin
                tod_next[11:8] = n_mu[3:0];
                if (n_mu[4]) begin
                    tod_next[15:12] = n_mt[3:0];
                    if (n_mt[4]) begin
                        tod_next[19:16] = n_hu[3:0];
                        if (n_hu[4]) begin
                            tod_next[23:20] = n_ht[3:0];
                        end
                    end
                end
            end
        end
    end else if (!tod_run_reg) begin
        // Stepping works on a stopped clock only, one digit, no carry
        if (p_tod[`OP_TOD_STEP + 5]) tod_next[23:20] = n_ht[3:0];
        if (p_tod[`OP_TOD_STEP + 4]) tod_next[19:16] = n_hu[3:0];
        if (p_tod[`OP_TOD_STEP + 3]) tod_next[15:12] = n_mt[3:0];
        if (p_tod[`OP_TOD_STEP + 2]) tod_next[11:8] = n_mu[3:0];
        if (p_tod[`OP_TOD_STEP + 1]) tod_next[7:4] = n_ct[3:0];
        if (p_tod[`OP_TOD_STEP]) tod_next[3:0] = n_cu[3:0];
    end
    if (p_tod[`OP_TOD_CLEAR]) begin
        tod_next = 24'h000000;
    end
end

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        tod_run_reg <= 1'b0;
        tick_cnt_reg <= 32'h00000000;
        o_tod <= 24'h000000;
    end else begin
        if (p_tod[`OP_TOD_STOP]) begin
            tod_run_reg <= 1'b0;
        end else if (p_tod[`OP_TOD_START]) begin
            tod_run_reg <= 1'b1;
        end
        if (!tod_run_reg || tick) begin
            tick_cnt_reg <= 32'h00000000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
        end
        o_tod <= tod_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave, zero wait states; read data captured in the setup cycle

wire setup = i_psel & ~i_penable;
wire wr_acc = i_psel & i_penable & i_pwrite;
wire mapped = (i_paddr == `OP_ADDR_CTRL) | (i_paddr == `OP_ADDR_PAC) |
              (i_paddr == `OP_ADDR_LAMPS) | (i_paddr == `OP_ADDR_TOD);

reg [31:0] rd_mux;
always @* begin
    case (i_paddr)
        `OP_ADDR_CTRL: rd_mux = {27'h0000000, ctrl_reg};
        `OP_ADDR_PAC: rd_mux = {14'h0000, o_pac};
        `OP_ADDR_LAMPS: rd_mux = {4'h0, o_stop_release_lamps, 1'b0, o_stop_select_lamps,
                                  1'b0, o_jump_select_lamps, o_mem_fault_lamps,
                                  5'h00, o_alarm, o_tod_fault_lamp, o_console_fault_lamp,
                                  o_processor_condition_lamp, o_instruction_fault_lamp,
                                  tod_run_reg, i_cpu_running};
        `OP_ADDR_TOD: rd_mux = {8'h00, o_tod};
        default: rd_mux = 32'h00000000;
    endcase
end

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        ctrl_reg <= `OP_CTRL_RESET;
        o_prdata <= 32'h00000000;
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
    end else begin
        o_pready <= 1'b1;
        if (setup) begin
            o_prdata <= i_pwrite ? 32'h00000000 : rd_mux;
            o_pslverr <= ~mapped;
        end
        if (wr_acc && i_paddr == `OP_ADDR_CTRL) begin
            ctrl_reg <= i_pwdata[`OP_CTRL_W-1:0];
        end
    end
end

endmodule // opanel_ctrl

//--- verif/opanel_props.sv
// Checker for the operator panel control block
`timescale 1ns/1ns
module opanel_props (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Processor side
    input wire i_cpu_running,
    input wire i_mj_valid,
    input wire [2:0] i_mj_jfield,
    // Lamps and commands
    input wire o_guard_lamp,
    input wire o_lockout_lamp,
    input wire [2:0] o_stop_select_lamps,
    input wire [3:0] o_stop_release_lamps,
    input wire [2:0] o_jump_select_lamps,
    input wire [2:0] o_jump_enable,
    input wire o_mj_halt,
    input wire [17:0] o_pac,
    input wire [17:0] o_pac_lamps,
    input wire [23:0] o_tod
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // Stop-lamp part of the halt decision, taken in the jump cycle
    wire sel_hit = i_mj_jfield == 3'h4 || (i_mj_jfield[2] && i_mj_jfield[1:0] != 2'h0 &&
        o_stop_select_lamps[i_mj_jfield[1:0] - 2'h1]);
    // Mode lamps trail the mode bits by a cycle, so the modes are read one cycle later
    sequence s_stop_jump;
        (i_mj_valid && sel_hit) ##1 (!o_guard_lamp && !o_lockout_lamp);
    endsequence
    sequence s_pass_jump;
        i_mj_valid ##1 (o_guard_lamp || o_lockout_lamp);
    endsequence
    a_jump_halts: assert property (s_stop_jump |-> o_mj_halt)
        else $error("manual jump did not halt");
    a_jump_passes: assert property (s_pass_jump |-> !o_mj_halt)
        else $error("manual jump halted wrongly");
    a_halt_has_cause: assert property (o_mj_halt |-> $past(i_mj_valid && sel_hit) &&
        !o_guard_lamp && !o_lockout_lamp)
        else $error("halt without a stopping jump");
    a_release_lamp_lit: assert property (s_stop_jump |->
        o_stop_release_lamps[$past(i_mj_jfield[1:0])])
        else $error("release lamp not lit after halt");
    a_top_bit_unused: assert property (!o_pac[17] && !o_pac_lamps[17])
        else $error("top address bit set");
    a_lamps_dark_run: assert property (i_cpu_running |=> o_pac_lamps == 18'h0)
        else $error("address lamps lit while running");
    a_lamps_follow_pac: assert property (!i_cpu_running |=>
        o_pac_lamps == $past(o_pac))
        else $error("address lamps differ from counter");
    a_jump_lamp_enable: assert property (o_jump_select_lamps == o_jump_enable)
        else $error("jump lamp and enable differ");
    a_tod_digits_legal: assert property (o_tod[23:20] <= 4'h2 && o_tod[15:12] <= 4'h5 &&
        o_tod[19:16] <= 4'h9 && o_tod[11:8] <= 4'h9 && o_tod[7:4] <= 4'h9 && o_tod[3:0] <= 4'h9)
        else $error("time digit out of range");
endmodule // opanel_props
////////////////////////////////////////
bind opanel_ctrl opanel_props u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_cpu_running(i_cpu_running),
    .i_mj_valid(i_mj_valid), .i_mj_jfield(i_mj_jfield), .o_guard_lamp(o_guard_lamp),
    .o_lockout_lamp(o_lockout_lamp), .o_stop_select_lamps(o_stop_select_lamps),
    .o_stop_release_lamps(o_stop_release_lamps), .o_jump_select_lamps(o_jump_select_lamps),
    .o_jump_enable(o_jump_enable), .o_mj_halt(o_mj_halt), .o_pac(o_pac),
    .o_pac_lamps(o_pac_lamps), .o_tod(o_tod)
);

//--- verif/opanel_cpu_model.sv
// Processor control section model: run state driven by panel commands
`timescale 1ns/1ns
module opanel_cpu_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Panel commands
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic i_halt,
    input wire logic i_clear,
    // Run state
    output logic o_running
);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_running <= 1'b0;
        end else if (i_stop || i_halt || i_clear) begin
            o_running <= 1'b0;
        end else if (i_start) begin
            o_running <= 1'b1;
        end
    end
endmodule // opanel_cpu_model

//--- verif/test_operator_panel_control.sv
// Self-checking bench for the operator panel control block
`timescale 1ns/1ns
module test_operator_panel_control;
    logic i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, mjv = 0, pld = 0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rd, seed = 32'h50357b78;
    logic [46:0] sw = 47'h0;
    logic [7:0] flt = 8'h00;
    logic [2:0] mjf = 3'h0;
    logic [16:0] pval = 17'h00000;
    wire [31:0] o_prdata;
    wire [17:0] o_pac_lamps;
    wire [23:0] o_tod;
    wire [6:0] cmd;
    wire [4:0] cl;
    wire o_pready, o_pslverr, run;
    logic err;
    int miscompares = 0, num_checks = 0, pac, ctl, jsel, ssel, srel, mem, f, n, b, h;
    int pc[7], ep[7];
    opanel_ctrl #(.TICK_CYCLES(4)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_addr_switches(sw[16:0]), .i_address_clear_switch(sw[17]),
        .i_jump_select_switches(sw[20:18]), .i_jump_release_switches(sw[23:21]),
        .i_stop_select_switches(sw[26:24]), .i_stop_release_switches(sw[29:27]),
        .i_fault_lamp_clear_switch(sw[30]), .i_alarm_silence_switch(sw[31]),
        .i_bootstrap_load_switch(sw[32]), .i_channel_clear_switch(sw[33]),
        .i_processor_clear_switch(sw[34]), .i_start_switch(sw[35]), .i_stop_switch(sw[36]),
        .i_tod_switches(sw[46:37]), .i_cpu_running(run), .i_pac_load(pld), .i_pac_value(pval),
        .i_mj_valid(mjv), .i_mj_jfield(mjf), .i_mem_parity_err(flt[3:0]),
        .i_illegal_op(flt[4]), .i_cond_fault(flt[5]), .i_console_fault(flt[6]),
        .i_tod_transient(flt[7]), .o_pac_lamps(o_pac_lamps), .o_tod_disable_lamp(cl[3]),
        .o_interval_timer_disable_lamp(cl[4]), .o_guard_lamp(cl[1]), .o_lockout_lamp(cl[0]),
        .o_parity_halt_lamp(cl[2]), .o_mem_fault_lamps(), .o_instruction_fault_lamp(),
        .o_processor_condition_lamp(), .o_console_fault_lamp(), .o_tod_fault_lamp(),
        .o_alarm(), .o_jump_select_lamps(), .o_stop_select_lamps(), .o_stop_release_lamps(),
        .o_pac(), .o_jump_enable(), .o_mj_halt(cmd[0]), .o_cpu_start(cmd[1]),
        .o_cpu_stop(cmd[2]), .o_cpu_clear(cmd[3]), .o_io_clear(cmd[4]),
        .o_master_clear(cmd[5]), .o_bootstrap_load(cmd[6]), .o_tod(o_tod));
    opanel_cpu_model cpu (.i_clk(i_clk), .i_rst(i_rst), .i_start(cmd[1]), .i_stop(cmd[2]),
        .i_halt(cmd[0]), .i_clear(cmd[3]), .o_running(run));
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        foreach (pc[k]) pc[k] += cmd[k];
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1;
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
        @(posedge i_clk);
    endtask
    // Held for many cycles so a repeated action would show
    task automatic press(input int s, input int e = -1);
        sw[s] <= 1'b1;
        repeat (6) @(posedge i_clk);
        sw[s] <= 1'b0;
        repeat (6) @(posedge i_clk);
        if (e >= 0) ep[e]++;
    endtask
    task automatic lamps();
        apb(0, 12'h008, 0);
        chk("lamps", rd, (srel << 24) | (ssel << 20) | (jsel << 16) | (mem << 12) | (f << 2) | run);
    endtask
    task automatic jump(input int j);
        mjv <= 1;
        mjf <= j[2:0];
        @(posedge i_clk);
        mjv <= 0;
        #1;
        h = (ctl & 3) == 0 && (j == 4 || (j > 4 && ssel[j - 5]));
        chk("halt", cmd[0], h);
        if (h) srel = 1 << (j - 4);
        ep[0] += h;
        @(posedge i_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 0;
        repeat (2) @(posedge i_clk);
        press(39);
        apb(0, 12'h010, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        press(17);
        for (int i = 0; i < 3; i++) begin
            b = {$random(seed)} % 17;
            press(b);
            pac |= 1 << b;
        end
        apb(0, 12'h004, 0);
        chk("pac", rd, pac);
        chk("pac lamps", o_pac_lamps, pac);
        press(17);
        apb(0, 12'h004, 0);
        chk("pac clear", rd, 0);
        pval <= $random(seed);
        pld <= 1;
        @(posedge i_clk);
        pld <= 0;
        pac = pval;
        press(35, 1);
        // Pick a switch whose bit is still zero, so an accepted press would show
        b = 0;
        while (b < 17 && pac[b]) b++;
        press(b);
        chk("dark", o_pac_lamps, 0);
        apb(0, 12'h004, 0);
        chk("pac run", rd, pac);
        press(36, 2);
        chk("stopped", run, 0);
        $display("address tests done");
        ctl = $random(seed) & 32'h1c;
        apb(1, 12'h000, ctl);
        apb(0, 12'h000, 0);
        chk("ctrl", rd, ctl);
        chk("ctrl lamps", cl, ctl);
        ctl = 0;
        apb(1, 12'h000, 0);
        press(24);
        press(25);
        ssel = 3;
        ctl = 1;
        apb(1, 12'h000, 1);
        press(20);
        chk("lockout lamp", cl, 1);
        press(27);
        press(26);
        press(17);
        press(38);
        jsel = 4;
        ssel = 2;
        jump(4);
        lamps();
        apb(0, 12'h004, 0);
        chk("lockout pac", rd, pac);
        ctl = 0;
        apb(1, 12'h000, 0);
        for (int j = 0; j < 8; j++) begin
            jump(j);
            if (h) begin
                lamps();
                press(35, 1);
                srel = 0;
            end
        end
        ctl = 2;
        apb(1, 12'h000, 2);
        jump(4);
        chk("guard lamp", cl, 2);
        jump(6);
        press(23);
        jsel = 0;
        lamps();
        $display("jump tests done");
        flt <= $random(seed) | 8'h81;
        @(posedge i_clk);
        flt <= 0;
        mem = flt[3:0];
        f = 5'h10 | flt[7:4];
        @(posedge i_clk);
        lamps();
        press(30);
        mem = 0;
        f &= 5'h18;
        lamps();
        press(31);
        f &= 5'h0f;
        lamps();
        press(37);
        f = 0;
        lamps();
        press(33, 4);
        ep[5]++;
        press(34, 3);
        press(32, 6);
        foreach (pc[k]) chk("pulses", pc[k], ep[k]);
        $display("fault and clear tests done");
        press(40);
        apb(0, 12'h00c, 0);
        chk("tod clear", rd, 0);
        for (int i = 5; i >= 0; i--) begin
            repeat (i == 5 ? 2 : i == 4 ? 3 : i == 3 ? 5 : 9) press(41 + i);
        end
        apb(0, 12'h00c, 0);
        chk("tod set", rd, 32'h00235999);
        sw[38] <= 1'b1;
        n = 0;
        while (o_tod === 24'h235999 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        #1;
        chk("tod wrap", o_tod, 0);
        @(posedge i_clk);
        sw[38] <= 1'b0;
        press(39);
        lamps();
        $display("clock tests done");
        finish_test();
    end
endmodule // test_operator_panel_control
